/* File: hdl/sld_driver.sv */
// Static segment driver: shift register, latch, backplane selection
`timescale 1ns/1ps
`default_nettype none
module sld_driver
  import sld_pkg::*;
#(
  parameter int SEGMENTS = SEG_COUNT
) (
  input wire logic core_clk, // 125 MHz system clock
  input wire logic reset_n, // Synchronous reset, active low
  input wire logic active_low_reset_n, // Device reset pin, active low
  input wire logic shift_clock, // Serial shift clock pin
  input wire logic serial_in, // Serial data pin
  input wire logic load, // Load strobe pin
  input wire logic backplane_in, // Backplane input pin
  input wire logic rc_timing_pin, // Oscillator pin
  output logic serial_out, // Cascade data out
  output logic backplane_out, // Backplane out
  output logic [SEGMENTS-1:0] segment_outputs // Segment drives
);
  if (SEGMENTS != SEG_COUNT) begin : g_seg_check
    $error("SEGMENTS must match SEG_COUNT");
  end

  // ------------------------------------------------------------
  // Pin synchronisers
  // ------------------------------------------------------------
  logic sck_rise, sck_fall, bp_lvl, bp_rise, osc_rise, din, ld, rst_pin;
  logic rst_meta;
  sld_edge_sync u_sck (.core_clk(core_clk), .reset_n(reset_n),
    .pin(shift_clock), .level(), .rise(sck_rise), .fall(sck_fall));
  sld_edge_sync u_bp (.core_clk(core_clk), .reset_n(reset_n),
    .pin(backplane_in), .level(bp_lvl), .rise(bp_rise), .fall());
  sld_edge_sync u_osc (.core_clk(core_clk), .reset_n(reset_n),
    .pin(rc_timing_pin), .level(), .rise(osc_rise), .fall());
  sld_edge_sync u_din (.core_clk(core_clk), .reset_n(reset_n),
    .pin(serial_in), .level(din), .rise(), .fall());
  sld_edge_sync u_ld (.core_clk(core_clk), .reset_n(reset_n),
    .pin(load), .level(ld), .rise(), .fall());

  // Pin reset: two flops, then acts like a reset on every later stage
  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      rst_meta <= 1'b0;
      rst_pin <= 1'b0;
    end else begin
      rst_meta <= active_low_reset_n;
      rst_pin <= rst_meta;
    end
  end
  logic dev_rst;
  assign dev_rst = !reset_n || !rst_pin;

  // ------------------------------------------------------------
  // Shift register, latch and load sequencing
  // ------------------------------------------------------------
  logic [SEGMENTS-1:0] shreg, next_shreg, latch, next_latch;
  logic [SEGMENTS-1:0] next_seg;
  logic sout, next_sout;
  logic [DELAY_CNT_W-1:0] sync_cnt, next_sync_cnt;
  logic [DELAY_CNT_W-1:0] async_cnt, next_async_cnt;
  logic ld_prev, next_ld_prev;
  logic do_load;

  always_comb begin
    next_shreg = shreg;
    next_sout = sout;
    next_sync_cnt = sync_cnt;
    next_async_cnt = async_cnt;
    next_ld_prev = ld;
    do_load = 1'b0;
    if (sck_rise) begin
      next_shreg = {shreg[SEGMENTS-2:0], din};
    end
    if (sck_fall) begin
      next_sout = shreg[SEGMENTS-1];
    end
    // Synchronous load counts shift rises from the load rise
    // Load rise that ends an asynchronous update must not arm it,
    // or the next preload would leak half-shifted data to the latch
    if (ld && !ld_prev && async_cnt != DELAY_LAST) begin
      next_sync_cnt = 4'h1;
    end
    if (sck_rise && sync_cnt != CNT_RESET) begin
      if (sync_cnt == DELAY_LAST) begin
        do_load = 1'b1;
        next_sync_cnt = CNT_RESET;
      end else begin
        next_sync_cnt = sync_cnt + 4'h1;
      end
    end
    // Asynchronous update counts backplane rises while load is low
    if (ld) begin
      next_async_cnt = CNT_RESET;
    end else if (bp_rise && async_cnt != DELAY_LAST) begin
      next_async_cnt = async_cnt + 4'h1;
      if (async_cnt == DELAY_LAST - 4'h1) begin
        do_load = 1'b1;
      end
    end
    // Last bit shifts in on the same rise that loads in synchronous mode
    next_latch = do_load ? next_shreg : latch;
    next_seg = latch ^ {SEGMENTS{bp_lvl}};
  end

  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      shreg <= SHIFT_RESET;
      latch <= LATCH_RESET;
      sout <= 1'b0;
      sync_cnt <= CNT_RESET;
      async_cnt <= CNT_RESET;
      ld_prev <= 1'b1;
      segment_outputs <= '0;
    end else begin
      shreg <= next_shreg;
      latch <= next_latch;
      sout <= next_sout;
      sync_cnt <= next_sync_cnt;
      async_cnt <= next_async_cnt;
      ld_prev <= next_ld_prev;
      segment_outputs <= next_seg;
    end
  end
  assign serial_out = sout;

  // ------------------------------------------------------------
  // Backplane source and divider
  // ------------------------------------------------------------
  sld_src_t src, next_src;
  logic [3:0] div, next_div;
  logic bp_out, next_bp_out;

  always_comb begin
    next_src = src;
    next_div = div;
    case (src)
      SLD_SRC_WAIT: begin
        if (osc_rise) next_src = SLD_SRC_INT;
        else if (bp_rise) next_src = SLD_SRC_EXT;
      end
      SLD_SRC_INT: next_src = SLD_SRC_INT;
      SLD_SRC_EXT: if (osc_rise) next_src = SLD_SRC_INT;
      default: next_src = SLD_SRC_WAIT;
    endcase
    if (osc_rise) next_div = div + 4'h1;
    if (src == SLD_SRC_INT) next_bp_out = div[3];
    else next_bp_out = bp_lvl;
  end

  always_ff @(posedge core_clk) begin
    if (dev_rst) begin
      src <= SLD_SRC_WAIT;
      div <= 4'h0;
      bp_out <= 1'b0;
    end else begin
      src <= next_src;
      div <= next_div;
      bp_out <= next_bp_out;
    end
  end
  assign backplane_out = bp_out;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  shift_move_a: assert property (@(posedge core_clk)
    disable iff (dev_rst) sck_rise |=> shreg[0] == $past(din))
    else $error("shift stage 0 missed serial input");
  sout_fall_a: assert property (@(posedge core_clk)
    disable iff (dev_rst)
    sck_fall |=> serial_out == $past(shreg[SEGMENTS-1]))
    else $error("serial out not updated on fall");
  reset_clear_a: assert property (@(posedge core_clk)
    dev_rst |=> shreg == '0)
    else $error("shift register not cleared");
  latch_clear_a: assert property (@(posedge core_clk)
    dev_rst |=> latch == '0)
    else $error("latch not cleared");
  seg_xor_a: assert property (@(posedge core_clk)
    disable iff (dev_rst)
    1'b1 |=> segment_outputs == ($past(latch) ^ {SEGMENTS{$past(bp_lvl)}}))
    else $error("segment not latch xor backplane");
  sync_load_a: assert property (@(posedge core_clk)
    disable iff (dev_rst)
    (sck_rise && sync_cnt == DELAY_LAST) |=> latch == shreg)
    else $error("synchronous transfer missed");
  async_load_a: assert property (@(posedge core_clk)
    disable iff (dev_rst)
    (!ld && bp_rise && async_cnt == 4'h7) |=> latch == $past(shreg))
    else $error("asynchronous update missed");
  int_sel_a: assert property (@(posedge core_clk)
    disable iff (dev_rst)
    (src == SLD_SRC_WAIT && osc_rise) |=> src == SLD_SRC_INT)
    else $error("oscillator did not select internal");
  ext_buf_a: assert property (@(posedge core_clk)
    disable iff (dev_rst)
    src != SLD_SRC_INT |=> backplane_out == $past(bp_lvl))
    else $error("backplane out not buffering input");
  bp_stop_a: assert property (@(posedge core_clk)
    dev_rst |=> !backplane_out)
    else $error("backplane out running in reset");
  div_half_a: assert property (@(posedge core_clk)
    disable iff (dev_rst)
    (src == SLD_SRC_INT) |=> backplane_out == $past(div[3]))
    else $error("divider output wrong");
  sync_c: cover property (@(posedge core_clk)
    sck_rise && sync_cnt == DELAY_LAST);
  async_c: cover property (@(posedge core_clk)
    !ld && bp_rise && async_cnt == 4'h7);
  int_c: cover property (@(posedge core_clk) src == SLD_SRC_INT);
endmodule
`default_nettype wire

/* File: hdl/sld_edge_sync.sv */
// Two-flop synchroniser with rise and fall detection
`timescale 1ns/1ps
`default_nettype none
module sld_edge_sync (
  input wire logic core_clk, // System clock
  input wire logic reset_n, // Synchronous reset
  input wire logic pin, // Asynchronous pin
  output logic level, // Synchronised level
  output logic rise, // One-cycle rising pulse
  output logic fall // One-cycle falling pulse
);
  logic meta;
  logic sync;
  logic prev;
  logic next_meta;
  logic next_sync;
  logic next_prev;

  always_comb begin
    next_meta = pin;
    next_sync = meta;
    next_prev = sync;
  end

  always_ff @(posedge core_clk) begin
    if (!reset_n) begin
      meta <= 1'b0;
      sync <= 1'b0;
      prev <= 1'b0;
    end else begin
      meta <= next_meta;
      sync <= next_sync;
      prev <= next_prev;
    end
  end

  assign level = sync;
  assign rise = sync & ~prev;
  assign fall = ~sync & prev;
endmodule
`default_nettype wire

/* File: hdl/sld_pkg.sv */
// Constants shared by the static segment driver
package sld_pkg;
  localparam int SEG_COUNT = 46;
  localparam int LOAD_DELAY = 8;
  localparam int OSC_DIVIDE = 16;
  localparam int DELAY_CNT_W = 4;
  localparam logic [SEG_COUNT-1:0] SHIFT_RESET = '0;
  localparam logic [SEG_COUNT-1:0] LATCH_RESET = '0;
  localparam logic [DELAY_CNT_W-1:0] CNT_RESET = 4'h0;
  localparam logic [DELAY_CNT_W-1:0] DELAY_LAST = 4'h8;
  localparam int RESET_MIN_NS = 20000;
  localparam int CLK_PERIOD_NS = 8;
  localparam int RESET_MIN_CYCLES =
    (RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [2:0] {
    SLD_SRC_WAIT = 3'b001,
    SLD_SRC_INT = 3'b010,
    SLD_SRC_EXT = 3'b100
  } sld_src_t;
endpackage

/* File: test/sld_host.sv */
// Host model that drives the serial side of the segment driver
`timescale 1ns/1ps
`default_nettype none
module sld_host (
  input wire logic core_clk, // System clock
  input wire logic serial_out, // Cascade data from the driver
  output logic shift_clock, // Shift clock pin
  output logic serial_in, // Serial data pin
  output logic load // Load strobe, idle high
);
  initial begin
    shift_clock = 1'b0;
    serial_in = 1'b0;
    load = 1'b1;
  end
  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task automatic set_load(input logic v);
    @(posedge core_clk);
    load <= v;
  endtask
  // Data flipped after the hold time so a stale bit never looks valid
  task automatic shift_bit(input logic b, output logic hi, output logic lo);
    @(posedge core_clk);
    serial_in <= b;
    wait_clk(5);
    shift_clock <= 1'b1;
    wait_clk(6);
    hi = serial_out;
    shift_clock <= 1'b0;
    serial_in <= ~b;
    wait_clk(6);
    lo = serial_out;
  endtask
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
// Self-checking bench for the static segment driver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import sld_pkg::*;
  localparam int LIMIT = 40000;
  typedef struct packed {logic [45:0] w; logic sync;} sld_row_t;
  logic core_clk, reset_n, active_low_reset_n, backplane_in, rc_timing_pin;
  logic bp_ext;
  logic shift_clock, serial_in, load, serial_out, backplane_out, osc_en;
  logic [45:0] segment_outputs, exp_sr, latch;
  int n_mismatch, tests_run, cyc, osc_cnt, c0;
  sld_row_t rows [4];
  sld_driver dut (.core_clk(core_clk), .reset_n(reset_n),
    .active_low_reset_n(active_low_reset_n), .shift_clock(shift_clock),
    .serial_in(serial_in), .load(load), .backplane_in(backplane_in),
    .rc_timing_pin(rc_timing_pin), .serial_out(serial_out),
    .backplane_out(backplane_out), .segment_outputs(segment_outputs));
  sld_host host (.core_clk(core_clk), .serial_out(serial_out),
    .shift_clock(shift_clock), .serial_in(serial_in), .load(load));
  initial core_clk = 1'b0;
  always #4 core_clk = ~core_clk;
  // Internal mode loops the generated backplane back to the input
  assign backplane_in = osc_en ? backplane_out : bp_ext;
  // Odd offset keeps backplane edges off the core clock edges
  initial begin
    bp_ext = 1'b0;
    #1.3;
    forever #62.5 bp_ext = ~bp_ext;
  end
  initial begin
    rc_timing_pin = 1'b0;
    wait (osc_en);
    forever begin
      host.wait_clk(5);
      rc_timing_pin <= ~rc_timing_pin;
    end
  end
  always @(posedge rc_timing_pin) osc_cnt++;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == LIMIT) begin
      n_mismatch++;
      end_sim();
    end
  end
  // ------------------------------
  // Tasks
  // ------------------------------
  task automatic check(input logic [45:0] seen, exp, input string what);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t %s: %h vs %h", $time, what, seen, exp);
    end
  endtask
  // Looked at while backplane is high, so segments show inverted latch
  task automatic chk_seg(input logic [45:0] exp);
    @(posedge backplane_in);
    host.wait_clk(6);
    check(segment_outputs, ~exp, "segments");
    if (!osc_en)
      check(46'(backplane_out), 46'h0000_0000_0001, "bp");
  endtask
  task automatic send(input logic [45:0] w, input logic sync);
    logic hi, lo, old;
    for (int i = 0; i < SEG_COUNT; i++) begin
      if (sync && i == 36) host.set_load(1'b0);
      if (sync && i == 38) host.set_load(1'b1);
      old = exp_sr[45];
      host.shift_bit(w[i], hi, lo);
      exp_sr = {exp_sr[44:0], w[i]};
      check(46'(hi), 46'(old), "dout high");
      check(46'(lo), 46'(exp_sr[45]), "dout low");
      if (sync && i == 44) chk_seg(latch);
    end
    if (sync) begin
      chk_seg(exp_sr);
      latch = exp_sr;
    end
  endtask
  task automatic upd(input logic [45:0] old_v, new_v);
    @(posedge backplane_in);
    host.wait_clk(2);
    host.set_load(1'b0);
    repeat (6) @(posedge backplane_in);
    chk_seg(old_v);
    chk_seg(new_v);
    @(posedge backplane_in);
    host.set_load(1'b1);
    latch = new_v;
  endtask
  task automatic end_sim();
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ------------------------------
  // Main sequence
  // ------------------------------
  initial begin
    rows = '{'{46'h0000_0000_0001, 1'b1}, '{46'h2AAA_AAAA_AAAA, 1'b0},
      '{46'h3FFF_FFFF_FFFF, 1'b1}, '{46'h1234_5678_9ABC, 1'b0}};
    {reset_n, active_low_reset_n, osc_en} = 3'b000;
    {exp_sr, latch} = '0;
    {n_mismatch, tests_run, cyc, osc_cnt} = '0;
    host.wait_clk(3);
    reset_n <= 1'b1;
    host.wait_clk(RESET_MIN_CYCLES);
    active_low_reset_n <= 1'b1;
    host.wait_clk(10);
    foreach (rows[i]) begin
      send(rows[i].w, rows[i].sync);
      if (!rows[i].sync) upd(latch, exp_sr);
    end
    // Reset with fresh data sitting in the shift register only
    send(46'h2D2D_2D2D_2D2D, 1'b0);
    host.wait_clk(1);
    active_low_reset_n <= 1'b0;
    repeat (3) begin
      @(posedge backplane_in);
      host.wait_clk(6);
      check(46'(backplane_out), '0, "bp in reset");
      check(segment_outputs, '0, "segs in reset");
    end
    host.wait_clk(RESET_MIN_CYCLES);
    active_low_reset_n <= 1'b1;
    {exp_sr, latch} = '0;
    host.wait_clk(10);
    upd('0, '0);
    host.wait_clk(1);
    osc_en <= 1'b1;
    repeat (20) @(posedge rc_timing_pin);
    @(backplane_out);
    repeat (2) begin
      c0 = osc_cnt;
      @(backplane_out);
      check(46'(osc_cnt - c0), 46'(OSC_DIVIDE / 2),
        "div");
    end
    // Segments must follow the looped internal backplane
    chk_seg('0);
    end_sim();
  end
endmodule
`default_nettype wire
